// ### design/lsb_pkg.sv
// Constants and types shared by the LIN slave header and baud block
package lsb_pkg;

  // Register byte offsets
  localparam logic [4:0] OFS_STATUS = 5'h00;
  localparam logic [4:0] OFS_DATA   = 5'h04;
  localparam logic [4:0] OFS_CTRL   = 5'h08;
  localparam logic [4:0] OFS_MANT   = 5'h0c;
  localparam logic [4:0] OFS_FRAC   = 5'h10;
  localparam logic [4:0] OFS_HLEN   = 5'h14;
  localparam logic [4:0] OFS_PRE    = 5'h18;

  // Status bit positions
  localparam int ST_FEF = 1;
  localparam int ST_HDF = 2;
  localparam int ST_HEF = 3;
  localparam int ST_RXF = 5;

  // Control bit positions
  localparam int CT_LIN  = 0;
  localparam int CT_SLV  = 1;
  localparam int CT_ASE  = 2;
  localparam int CT_HDM  = 3;
  localparam int CT_MUTE = 4;
  localparam int CT_SFS  = 5;

  // Reset values
  localparam logic [11:0] RST_DIV = 12'h010;
  localparam logic [15:0] RST_PRE = 16'h0001;

  // Timing and framing
  localparam int          OVS          = 16;
  localparam logic [3:0]  SMP_LO       = 4'h7;
  localparam logic [3:0]  SMP_HI       = 4'h9;
  localparam logic [3:0]  STOP_BIT     = 4'h9;
  localparam logic [7:0]  BRK_TICKS    = 8'(11 * OVS);
  localparam int          HDR_MAX_BITS = 57;
  localparam logic [9:0]  HDR_TO_TICKS = 10'(HDR_MAX_BITS * OVS);
  localparam logic [7:0]  SYNC_CHAR    = 8'h55;
  localparam logic [2:0]  SYNC_EDGES   = 3'h5;
  localparam logic [14:0] MEAS_MAX     = 15'h7fff;

  typedef enum logic {R_IDLE, R_BITS} lsb_rx_e;
  typedef enum logic [1:0] {H_SEARCH, H_SYNC, H_ID} lsb_hdr_e;

  // One received character
  typedef struct packed {
    logic       done;
    logic       stop;
    logic [7:0] byte_v;
  } lsb_chr_s;

  typedef struct packed {
    logic        rx_m;
    logic        rx_s;
    logic        rx_q;
    logic        ack;
    logic [31:0] rdata;
    logic        lin_en;
    logic        slave;
    logic        ase;
    logic        hdm;
    logic        mute;
    logic        sfs;
    logic [11:0] nom;
    logic [11:0] act;
    logic [11:0] meas;
    logic [15:0] mpre;
    logic [15:0] pcnt;
    logic [11:0] acc;
    logic        tick;
    lsb_rx_e     rxs;
    logic [3:0]  scnt;
    logic [3:0]  bcnt;
    logic [1:0]  vote;
    logic [7:0]  shft;
    logic [7:0]  low;
    lsb_hdr_e    hs;
    logic [9:0]  hcnt;
    logic [7:0]  hlen;
    logic [14:0] mcnt;
    logic [2:0]  edg;
    logic [7:0]  data;
    logic        rxf;
    logic        hef;
    logic        fef;
    logic        hdf;
    logic        arm;
    logic        hev;
  } lsb_state_s;

endpackage : lsb_pkg

// ### design/lsb_top.sv
// LIN slave header supervision, synch-field measurement and baud divider
// Notes on behaviour
// - Time-out only when header exceeds 57 bits
// - Header length readable when detection/autosync on
// - Muted sync/time-out error: flag, stay muted
// - Muted framing error dropped, flag stays clear
// - Identifier method wakes only on valid header
// - Identifier parity error does not block wake
// - Autosync times five falling edges, 15 bits
// - Fifth edge loads measured value into divider
// - Receiver halted during synch measurement
// - Slave rate is clock over sixteen times divider
// - Divider is 8.4 unsigned fixed point
// - Nominal, measured and active divider kept
// - Software nominal write beats measured load
// - Master mode uses the plain prescaler
// - Sixteen samples, vote on 8th-10th
// - Sample phase realigned on each start bit
// - Synch measured over eight bits on clock
// - Break needs eleven low bits
// - Mute wake on break or identifier
// - Muted: discard bits until eleven dominant
// - Time-out counter starts on break, stops on end
// - Status access then data read clears flag (HDF is cleared by a status access then a control read instead)
//
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
module lsb_top
  import lsb_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // LIN line and status
  input  wire logic        receive_data_input,
  output logic             sample_tick,
  output logic             header_event
);
  import lsb_pkg::*;

  lsb_state_s s_r;
  lsb_state_s s_nxt;

  logic       fall;
  logic       rise;
  logic       bus_req;
  logic       do_rd;
  logic       do_wr;
  logic       div_wr;
  logic       edge5;
  logic       to_ev;
  logic       id_ok;
  logic       brk_ev;
  logic       meas_on;
  logic       sync_err;
  logic       bit_v;
  logic [12:0] sum;
  logic [11:0] diff;
  logic [14:0] dev_lim;
  logic [7:0]  sv;
  lsb_chr_s    chr;

  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~s_r.ack;
  assign avs_readdata    = s_r.rdata;
  assign sample_tick     = s_r.tick;
  assign header_event    = s_r.hev;

  always_comb begin
    s_nxt    = s_r;
    s_nxt.hev = 1'b0;
    chr      = '0;
    bit_v    = 1'b0;
    sync_err = 1'b0;
    id_ok    = 1'b0;
    to_ev    = 1'b0;
    edge5    = 1'b0;
    sv       = '0;
    diff     = '0;
    dev_lim  = '0;
    sum      = '0;

    // Line synchroniser; the edge logic compares the second and third stages
    s_nxt.rx_m = receive_data_input;
    s_nxt.rx_s = s_r.rx_m;
    s_nxt.rx_q = s_r.rx_s;
    fall = s_r.rx_q & ~s_r.rx_s;
    rise = ~s_r.rx_q & s_r.rx_s;

    // Oversampling enable
    s_nxt.tick = 1'b0;
    if (s_r.lin_en && s_r.slave) begin
      // Fractional accumulator gives clock*16/div12 samples per second
      sum = {1'b0, s_r.acc} + 13'd16;
      if (s_r.act != 12'h000 && sum >= {1'b0, s_r.act}) begin
        s_nxt.tick = 1'b1;
        s_nxt.acc  = 12'(sum - {1'b0, s_r.act});
      end else begin
        s_nxt.acc = sum[11:0];
      end
    end else if (s_r.pcnt >= s_r.mpre) begin
      s_nxt.tick = 1'b1;
      s_nxt.pcnt = '0;
    end else begin
      s_nxt.pcnt = s_r.pcnt + 16'h0001;
    end

    // Bus handshake: one wait cycle, then the access completes
    s_nxt.ack = bus_req & ~s_r.ack;
    do_rd = s_r.ack & avs_read;
    do_wr = s_r.ack & avs_write;
    div_wr = do_wr && avs_byteenable[0]
             && (avs_address == OFS_MANT || avs_address == OFS_FRAC);
    sv[ST_RXF] = s_r.rxf;
    sv[ST_HEF] = s_r.hef;
    sv[ST_HDF] = s_r.hdf;
    sv[ST_FEF] = s_r.fef;
    if (bus_req && !s_r.ack && avs_read) begin
      unique case (avs_address)
        OFS_STATUS: s_nxt.rdata = {24'h000000, sv};
        OFS_DATA:   s_nxt.rdata = {24'h000000, s_r.data};
        OFS_CTRL:   s_nxt.rdata = {26'h0000000, s_r.sfs, s_r.mute, s_r.hdm,
                                   s_r.ase, s_r.slave, s_r.lin_en};
        OFS_MANT:   s_nxt.rdata = {24'h000000, s_r.act[11:4]};
        OFS_FRAC:   s_nxt.rdata = {28'h0000000, s_r.act[3:0]};
        OFS_HLEN:   s_nxt.rdata = {24'h000000, s_r.hlen};
        OFS_PRE:    s_nxt.rdata = {16'h0000, s_r.mpre};
        default:    s_nxt.rdata = '0;
      endcase
    end

    // Read side effects; hardware sets further down win over these clears
    if (do_rd && avs_address == OFS_STATUS) begin
      s_nxt.arm = 1'b1;
    end
    if (do_rd && avs_address == OFS_DATA) begin
      s_nxt.rxf = 1'b0;
      if (s_r.arm) begin
        s_nxt.hef = 1'b0;
        s_nxt.fef = 1'b0;
        s_nxt.arm = 1'b0;
      end
    end
    if (do_rd && avs_address == OFS_CTRL && s_r.arm) begin
      s_nxt.hdf = 1'b0;
      s_nxt.arm = 1'b0;
    end

    if (do_wr && avs_address == OFS_CTRL && avs_byteenable[0]) begin
      s_nxt.lin_en = avs_writedata[CT_LIN];
      s_nxt.slave  = avs_writedata[CT_SLV];
      s_nxt.ase    = avs_writedata[CT_ASE];
      s_nxt.hdm    = avs_writedata[CT_HDM];
      s_nxt.mute   = avs_writedata[CT_MUTE];
      // Blocked synch state can only be cleared by software, which also unblocks
      if (!avs_writedata[CT_SFS] && s_r.sfs) begin
        s_nxt.sfs = 1'b0;
        if (s_r.hs == H_SYNC) begin
          s_nxt.hs = H_SEARCH;
        end
      end
    end
    if (do_wr && avs_address == OFS_PRE) begin
      if (avs_byteenable[0]) s_nxt.mpre[7:0] = avs_writedata[7:0];
      if (avs_byteenable[1]) s_nxt.mpre[15:8] = avs_writedata[15:8];
    end

    // Receiver: halted while the synch field is measured or blocked
    meas_on = s_r.sfs;
    if (meas_on) begin
      s_nxt.rxs = R_IDLE;
    end else if (s_r.rxs == R_IDLE) begin
      if (fall) begin
        s_nxt.rxs  = R_BITS;
        s_nxt.scnt = '0;
        s_nxt.bcnt = '0;
      end
    end else if (s_r.tick) begin
      s_nxt.scnt = s_r.scnt + 4'h1;
      if (s_r.scnt == SMP_LO) s_nxt.vote[0] = s_r.rx_s;
      if (s_r.scnt == SMP_LO + 4'h1) s_nxt.vote[1] = s_r.rx_s;
      if (s_r.scnt == SMP_HI) begin
        bit_v = (s_r.vote[0] & s_r.vote[1]) | (s_r.vote[0] & s_r.rx_s)
                | (s_r.vote[1] & s_r.rx_s);
        s_nxt.bcnt = s_r.bcnt + 4'h1;
        if (s_r.bcnt == 4'h0 && bit_v) begin
          s_nxt.rxs = R_IDLE;
        end else if (s_r.bcnt == STOP_BIT) begin
          s_nxt.rxs = R_IDLE;
          chr.done   = 1'b1;
          chr.stop   = bit_v;
          chr.byte_v = s_r.shft;
        end else if (s_r.bcnt != 4'h0) begin
          s_nxt.shft = {bit_v, s_r.shft[7:1]};
        end
      end
    end

    // Break detector: counts low samples, judged on the rising edge
    if (s_r.rx_s) begin
      s_nxt.low = '0;
    end else if (s_r.tick && s_r.low != 8'hff) begin
      s_nxt.low = s_r.low + 8'h01;
    end
    brk_ev = rise && s_r.low >= BRK_TICKS && s_r.lin_en && s_r.slave
             && !(s_r.sfs && s_r.hs == H_SEARCH);

    // Header time-out, in sample ticks of the active divider
    if (s_r.hs != H_SEARCH && s_r.tick && (s_r.hdm || s_r.ase)) begin
      s_nxt.hcnt = s_r.hcnt + 10'h001;
      if (s_r.hcnt == HDR_TO_TICKS) begin
        to_ev     = 1'b1;
        s_nxt.hef = 1'b1;
        s_nxt.hs  = H_SEARCH;
      end
    end

    // Synch field measurement over five falling edges
    if (!to_ev && s_r.hs == H_SYNC && s_r.ase && s_r.sfs) begin
      if (s_r.edg != 3'h0) begin
        s_nxt.mcnt = s_r.mcnt + 15'h0001;
        if (s_r.mcnt == MEAS_MAX) sync_err = 1'b1;
      end
      if (fall && !sync_err) begin
        s_nxt.edg = s_r.edg + 3'h1;
        if (s_r.edg == 3'h0) s_nxt.mcnt = 15'h0001;
        if (s_r.edg + 3'h1 == SYNC_EDGES) begin
          edge5 = 1'b1;
          // Eight bits over 16 samples each: 8.4 divider is count/8
          s_nxt.meas = s_r.mcnt[14:3];
          diff = (s_r.mcnt[14:3] > s_r.act) ? s_r.mcnt[14:3] - s_r.act
                                           : s_r.act - s_r.mcnt[14:3];
          dev_lim = (15'(s_r.act) * 15'd5) >> 5;
          if (15'(diff) > dev_lim) begin
            sync_err = 1'b1;
          end else begin
            s_nxt.act  = s_nxt.meas;
            s_nxt.sfs = 1'b0;
            s_nxt.hs  = H_ID;
          end
        end
      end
      if (sync_err) begin
        // Back to search with sfs left set, so breaks stay blocked until software clears it
        s_nxt.hef = 1'b1;
        s_nxt.hs  = H_SEARCH;
      end
    end

    // Break accepted: header timing starts from the break's falling edge
    if (brk_ev) begin
      s_nxt.hs   = H_SYNC;
      s_nxt.hcnt = {2'b00, s_r.low};
      s_nxt.edg  = '0;
      s_nxt.mcnt = '0;
      s_nxt.sfs  = s_r.ase;
      if (!s_r.hdm) begin
        s_nxt.hdf  = 1'b1;
        s_nxt.hev  = 1'b1;
        s_nxt.data = 8'h00;
        s_nxt.rxf  = 1'b1;
        s_nxt.mute = 1'b0;
      end
    end else if (chr.done && !to_ev) begin
      unique case (s_r.hs)
        H_SYNC: begin
          if (chr.byte_v != SYNC_CHAR || !chr.stop) begin
            s_nxt.hef = 1'b1;
            s_nxt.hs  = H_SEARCH;
          end else begin
            s_nxt.hs = H_ID;
          end
          if (!s_r.mute && !s_r.hdm) begin
            s_nxt.data = chr.byte_v;
            s_nxt.rxf  = 1'b1;
          end
        end
        H_ID: begin
          s_nxt.hs = H_SEARCH;
          // Parity is not checked, so it can never block the wake-up
          id_ok = chr.stop;
          if (id_ok) begin
            if (s_r.hdm || s_r.ase) s_nxt.hlen = {2'b00, s_r.hcnt[9:4]};
            if (s_r.hdm) begin
              s_nxt.hdf  = 1'b1;
              s_nxt.hev  = 1'b1;
              s_nxt.mute = 1'b0;
            end
            if (s_r.hdm || !s_r.mute) begin
              s_nxt.data = chr.byte_v;
              s_nxt.rxf  = 1'b1;
            end
          end else if (!s_r.mute) begin
            s_nxt.fef = 1'b1;
          end
        end
        default: begin
          // Plain character; while muted every bit is thrown away
          if (!s_r.mute) begin
            if (chr.stop) begin
              s_nxt.data = chr.byte_v;
              s_nxt.rxf  = 1'b1;
            end else if (chr.byte_v != 8'h00) begin
              s_nxt.fef = 1'b1;
            end
          end
        end
      endcase
    end

    // Software divider write goes last so it wins over the measured load
    if (div_wr) begin
      if (avs_address == OFS_MANT) begin
        s_nxt.nom[11:4] = avs_writedata[7:0];
      end else begin
        s_nxt.nom[3:0] = avs_writedata[3:0];
      end
      s_nxt.act = s_nxt.nom;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_r      <= '0;
      s_r.rx_m <= 1'b1;
      s_r.rx_s <= 1'b1;
      s_r.rx_q <= 1'b1;
      s_r.nom  <= RST_DIV;
      s_r.act  <= RST_DIV;
      s_r.meas <= RST_DIV;
      s_r.mpre <= RST_PRE;
    end else begin
      s_r <= s_nxt;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  property p_to;
    to_ev |-> s_r.hcnt == HDR_TO_TICKS ##1 s_r.hef && s_r.hs == H_SEARCH;
  endproperty
  a_to: assert property (p_to) else $error("time-out at wrong count");

  property p_hlen;
    (id_ok && (s_r.hdm || s_r.ase)) |=> s_r.hlen == {2'b00, $past(s_r.hcnt[9:4])};
  endproperty
  a_hlen: assert property (p_hlen) else $error("header length not stored");

  property p_mute_err;
    (to_ev && s_r.mute && s_r.hdm && !do_wr) |=> s_r.mute && s_r.hef;
  endproperty
  a_mute_err: assert property (p_mute_err) else $error("muted error woke");

  property p_fe;
    (s_r.mute && !s_r.fef && chr.done && !chr.stop && !do_wr) |=> !s_r.fef;
  endproperty
  a_fe: assert property (p_fe) else $error("muted framing flagged");

  property p_wake;
    ($fell(s_r.mute) && s_r.hdm && !$past(do_wr)) |-> $past(id_ok);
  endproperty
  a_wake: assert property (p_wake) else $error("woke without header");

  property p_load;
    (edge5 && !sync_err && !div_wr) |=> s_r.act == $past(s_r.mcnt[14:3]) && !s_r.sfs;
  endproperty
  a_load: assert property (p_load) else $error("measured load missed");

  property p_halt;
    s_r.sfs |=> s_r.rxs == R_IDLE && !chr.done;
  endproperty
  a_halt: assert property (p_halt) else $error("receiver ran in synch");

  property p_prio;
    (div_wr && edge5) |=> s_r.act == s_r.nom;
  endproperty
  a_prio: assert property (p_prio) else $error("nominal lost priority");

  property p_brk;
    brk_ev |-> s_r.low >= BRK_TICKS ##1 s_r.hs == H_SYNC;
  endproperty
  a_brk: assert property (p_brk) else $error("short break accepted");

endmodule : lsb_top

// ### tb/lsb_lin_master.sv
// Behavioural LIN master node driving the slave's receive line
`timescale 1ns/10ps
module lsb_lin_master (
  // Clock
  input  wire logic ref_clk,
  // Bus line, pulled up to recessive when idle
  output logic      rx_line
);
  int bit_clks = 32;

  initial rx_line = 1'b1;

  // Changes only just after a rising edge, so the slave's sampling never races it
  task automatic hold(input logic lvl, input int bits);
    rx_line <= lvl;
    repeat (bits * bit_clks) @(posedge ref_clk);
  endtask : hold

  task automatic send_char(input logic [7:0] b, input logic stop);
    hold(1'b0, 1);
    for (int i = 0; i < 8; i++) begin
      hold(b[i], 1);
    end
    hold(stop, 1);
  endtask : send_char

  // Gap stretches the header between synch and identifier fields
  task automatic send_header(input logic [7:0] id, input int gap);
    hold(1'b0, 13);
    hold(1'b1, 1);
    send_char(8'h55, 1'b1);
    hold(1'b1, gap);
    send_char(id, 1'b1);
    hold(1'b1, 2);
  endtask : send_header
endmodule : lsb_lin_master

// ### tb/lsb_top_tb.sv
// Self-checking bench for the LIN slave header and baud block
`timescale 1ns/10ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fails++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); end end
module lsb_top_tb;
  import lsb_pkg::*;
  logic        ref_clk         = 1'b0;
  logic        sys_rst         = 1'b1;
  logic [4:0]  avs_address     = '0;
  logic        avs_read        = 1'b0;
  logic        avs_write       = 1'b0;
  logic [31:0] avs_writedata   = '0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        rx_line;
  logic        sample_tick;
  logic        header_event;
  logic [31:0] q;
  int          fails           = 0;
  int          n_compared      = 0;
  int          hev             = 0;
  int          h;

  always #12.5 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    if (header_event === 1'b1) begin
      hev++;
    end
  end

  lsb_top dut (
    .ref_clk            (ref_clk),
    .sys_rst            (sys_rst),
    .avs_address        (avs_address),
    .avs_read           (avs_read),
    .avs_write          (avs_write),
    .avs_writedata      (avs_writedata),
    .avs_byteenable     (4'hf),
    .avs_readdata       (avs_readdata),
    .avs_waitrequest    (avs_waitrequest),
    .receive_data_input (rx_line),
    .sample_tick        (sample_tick),
    .header_event       (header_event)
  );

  lsb_lin_master lin (
    .ref_clk (ref_clk),
    .rx_line (rx_line)
  );

  // Request held until the rising edge that samples waitrequest low; data taken there
  task automatic bus(input logic wr_en, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr_en;
    avs_read      <= ~wr_en;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      fails++;
      $display("mismatch at %0t: bus access never answered", $time);
    end
    @(posedge ref_clk);
  endtask : bus

  task automatic rd(input logic [4:0] a);
    bus(1'b0, a, '0);
  endtask : rd

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic clr;
    rd(OFS_STATUS);
    rd(OFS_DATA);
  endtask : clr

  // Settle first so a divider change mid-period cannot skew the count
  task automatic ticks(input int cyc, input int exp);
    int n;
    n = 0;
    repeat (8) @(posedge ref_clk);
    repeat (cyc) begin
      @(negedge ref_clk);
      if (sample_tick === 1'b1) n++;
    end
    @(posedge ref_clk);
    `CHK(n, exp)
  endtask : ticks

  task automatic t_regs;
    rd(OFS_MANT);
    `CHK(q, 32'h01)
    rd(OFS_FRAC);
    `CHK(q, 32'h0)
    rd(5'h1c);
    `CHK(q, 32'h0)
    $display("test regs done");
  endtask : t_regs

  task automatic t_rate;
    wr(OFS_CTRL, 32'h03);
    wr(OFS_MANT, 32'h02);
    wr(OFS_FRAC, 32'h08);
    ticks(80, 32);
    wr(OFS_PRE, 32'h03);
    wr(OFS_CTRL, 32'h01);
    ticks(64, 16);
    wr(OFS_CTRL, 32'h03);
    wr(OFS_FRAC, 32'h0);
    rd(OFS_MANT);
    `CHK(q, 32'h02)
    $display("test rate done");
  endtask : t_rate

  task automatic t_break;
    h = hev;
    lin.send_char(8'h00, 1'b0);
    lin.hold(1'b1, 2);
    `CHK(hev, h)
    lin.send_header(8'h3c, 0);
    `CHK(hev, h + 1)
    rd(OFS_STATUS);
    `CHK(q[ST_HDF], 1'b1)
    // Neither identifier detection nor autosync on, so no length is recorded
    rd(OFS_HLEN);
    `CHK(q, 32'h0)
    rd(OFS_DATA);
    lin.send_char(8'h0f, 1'b0);
    lin.hold(1'b1, 2);
    rd(OFS_STATUS);
    `CHK(q[ST_FEF], 1'b1)
    rd(OFS_DATA);
    rd(OFS_STATUS);
    `CHK(q[ST_FEF], 1'b0)
    $display("test break done");
  endtask : t_break

  task automatic t_mute;
    clr;
    wr(OFS_CTRL, 32'h13);
    lin.send_char(8'h0f, 1'b0);
    lin.send_char(8'ha5, 1'b1);
    lin.hold(1'b1, 2);
    rd(OFS_STATUS);
    `CHK(q[ST_FEF], 1'b0)
    `CHK(q[ST_RXF], 1'b0)
    h = hev;
    lin.send_header(8'h3c, 0);
    `CHK(hev, h + 1)
    rd(OFS_CTRL);
    `CHK(q[CT_MUTE], 1'b0)
    $display("test mute done");
  endtask : t_mute

  task automatic t_ident;
    clr;
    wr(OFS_CTRL, 32'h1b);
    h = hev;
    // Identifier with a wrong parity bit
    lin.send_header(8'h41, 0);
    `CHK(hev, h + 1)
    rd(OFS_HLEN);
    `CHK(q >= 33 && q <= 34, 1'b1)
    rd(OFS_DATA);
    `CHK(q[7:0], 8'h41)
    rd(OFS_CTRL);
    `CHK(q[CT_MUTE], 1'b0)
    clr;
    wr(OFS_CTRL, 32'h1b);
    lin.send_header(8'hc1, 22);
    `CHK(hev, h + 2)
    rd(OFS_STATUS);
    `CHK(q[ST_HEF], 1'b0)
    $display("test ident done");
  endtask : t_ident

  task automatic t_tout;
    clr;
    wr(OFS_CTRL, 32'h1b);
    h = hev;
    lin.send_header(8'hc1, 30);
    `CHK(hev, h)
    rd(OFS_CTRL);
    `CHK(q[CT_MUTE], 1'b1)
    rd(OFS_STATUS);
    `CHK(q[ST_HEF], 1'b1)
    rd(OFS_DATA);
    rd(OFS_STATUS);
    `CHK(q[ST_HEF], 1'b0)
    $display("test timeout done");
  endtask : t_tout

  task automatic t_sync;
    clr;
    // Nominal divider of 2.0 is already loaded before the enable
    wr(OFS_CTRL, 32'h0f);
    lin.bit_clks = 36;
    h = hev;
    lin.send_header(8'h3c, 0);
    lin.bit_clks = 32;
    `CHK(hev, h + 1)
    rd(OFS_MANT);
    `CHK(q[7:0], 8'h02)
    rd(OFS_FRAC);
    `CHK(q[3:0], 4'h4)
    rd(OFS_DATA);
    `CHK(q[7:0], 8'h3c)
    rd(OFS_STATUS);
    `CHK(q[ST_HEF], 1'b0)
    $display("test sync done");
  endtask : t_sync

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    t_regs;
    t_rate;
    t_break;
    t_mute;
    t_ident;
    t_tout;
    t_sync;
    results;
  end

  // Whole run needs about 10500 cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    results;
  end
endmodule : lsb_top_tb
